// [core/fpc_regs.svh]
// timing, command codes and field positions for the flash command host
`ifndef FPC_REGS_SVH
`define FPC_REGS_SVH
`define FPC_CLK_MHZ        125
`define FPC_UNLOCK1_ADDR   22'h000555
`define FPC_UNLOCK2_ADDR   22'h0002AA
`define FPC_UNLOCK1_DATA   16'h00AA
`define FPC_UNLOCK2_DATA   16'h0055
`define FPC_CMD_PROGRAM    16'h00A0
`define FPC_CMD_BYPASS     16'h0020
`define FPC_CMD_ERASE_SET  16'h0080
`define FPC_CMD_CHIP_ERASE 16'h0010
`define FPC_CMD_SECT_ERASE 16'h0030
`define FPC_CMD_BYP_RST1   16'h0090
`define FPC_CMD_BYP_RST2   16'h0000
`define FPC_CMD_RESET      16'h00F0
`define FPC_CMD_SUSPEND    16'h00B0
// strobe phase times in ns
`define FPC_T_SETUP_NS     20
`define FPC_T_PULSE_NS     40
`define FPC_T_HOLD_NS      30
// sector erase accumulation window in ns; host flags the window late when it expires
`define FPC_T_WINDOW_NS    50000
`define FPC_T_RESET_NS     500
// status bit positions on the data bus
`define FPC_BIT_POLL       7
`define FPC_BIT_TOGGLE     6
`define FPC_BIT_TLE        5
`define FPC_BIT_WINDOW     3
`define FPC_BIT_ETOGGLE    2
`endif

// [core/fpc_pkg.sv]
// types shared by the flash command host
package fpc_pkg;
  typedef logic [21:0] fpc_addr_t;
  typedef logic [15:0] fpc_data_t;
  // user commands
  typedef enum logic [3:0] {
    FPC_OP_PROGRAM    = 4'h0,
    FPC_OP_BYP_ENTER  = 4'h1,
    FPC_OP_BYP_PROG   = 4'h2,
    FPC_OP_BYP_EXIT   = 4'h3,
    FPC_OP_CHIP_ERASE = 4'h4,
    FPC_OP_SECT_ERASE = 4'h5,
    FPC_OP_SECT_ADD   = 4'h6,
    FPC_OP_RESET      = 4'h7,
    FPC_OP_SUSPEND    = 4'h8,
    FPC_OP_HW_RESET   = 4'h9
  } fpc_op_t;
endpackage : fpc_pkg

// [core/fpc_strobe_if.sv]
// handshake between sequencer and the bus strobe engine
`timescale 1ns/10ps
interface fpc_strobe_if;
  logic        req;
  logic [21:0] addr;
  logic [15:0] data;
  logic        done;
  modport seq (output req, output addr, output data, input done);
  modport eng (input req, input addr, input data, output done);
endinterface : fpc_strobe_if

// [core/fpc_strobe.sv]
// one flash write cycle: address, chip select, write strobe, data
`timescale 1ns/10ps
`include "fpc_regs.svh"
module fpc_strobe (
  input  wire logic    i_clk,
  input  wire logic    i_rst,
  fpc_strobe_if.eng    bus,
  output logic         o_we_n,
  output logic         o_ce_n,
  output logic [21:0]  o_addr,
  output logic [15:0]  o_data,
  output logic         o_data_oe
);
  import fpc_pkg::*;
  localparam int SETUP_CYC = (`FPC_T_SETUP_NS * `FPC_CLK_MHZ + 999) / 1000;
  localparam int PULSE_CYC = (`FPC_T_PULSE_NS * `FPC_CLK_MHZ + 999) / 1000;
  localparam int HOLD_CYC  = (`FPC_T_HOLD_NS * `FPC_CLK_MHZ + 999) / 1000;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_SETUP = 4'b0010,
    ST_PULSE = 4'b0100,
    ST_HOLD  = 4'b1000
  } fpc_stb_t;
  fpc_stb_t   state_ff;
  logic [3:0] cnt_ff;
  // phase sequencer; address before strobe falls, data held past its rise
  always_ff @(posedge i_clk) begin
    bus.done <= 1'b0;
    if (i_rst) begin
      state_ff  <= ST_IDLE;
      cnt_ff    <= 4'h0;
      o_we_n    <= 1'b1;
      o_ce_n    <= 1'b1;
      o_addr    <= '0;
      o_data    <= '0;
      o_data_oe <= 1'b0;
    end else begin
      unique case (state_ff)
        ST_IDLE: if (bus.req) begin
          o_addr    <= bus.addr;
          o_data    <= bus.data;
          o_data_oe <= 1'b1;
          o_ce_n    <= 1'b0;
          cnt_ff    <= 4'(SETUP_CYC);
          state_ff  <= ST_SETUP;
        end
        ST_SETUP: if (cnt_ff <= 4'h1) begin
          o_we_n   <= 1'b0;
          cnt_ff   <= 4'(PULSE_CYC);
          state_ff <= ST_PULSE;
        end else cnt_ff <= cnt_ff - 4'h1;
        ST_PULSE: if (cnt_ff <= 4'h1) begin
          o_we_n   <= 1'b1;
          cnt_ff   <= 4'(HOLD_CYC);
          state_ff <= ST_HOLD;
        end else cnt_ff <= cnt_ff - 4'h1;
        ST_HOLD: if (cnt_ff <= 4'h1) begin
          o_ce_n    <= 1'b1;
          o_data_oe <= 1'b0;
          bus.done  <= 1'b1;
          state_ff  <= ST_IDLE;
        end else cnt_ff <= cnt_ff - 4'h1;
      endcase
    end
  end
endmodule : fpc_strobe

// [core/fpc_host.sv]
// host controller that issues program and erase sequences to the flash
`timescale 1ns/10ps
`include "fpc_regs.svh"
// Function
// - standard program is two unlocks, A0 set-up, then address and data.
// - hardware reset aborts program; host takes hardware reset only when idle, not while busy, and reissues nothing.
// - bypass entered by two unlocks then 20h to bank.
// - bypass program is A0h then address and data, repeatable.
// - bypass exit is 90h to bank, then 00h anywhere.
// - accelerate pin high only during accelerated program; host drives it high while the synchronized request is held and the host is idle or in bypass.
// - chip erase is unlock, unlock, 80h, unlock, unlock, 10h.
// - sector erase is five set-up writes then sector address with 30h.
// - extra sector writes under 50 us apart; host times the 50 us window and flags it late when it expires.
// - address on later falling strobe edge, data on earlier rising edge.
module fpc_host (
  input  wire logic            I_CORE_CLK,
  input  wire logic            I_RST,
  input  wire logic            i_cmd_valid,
  input  wire fpc_pkg::fpc_op_t i_cmd_op,
  input  wire fpc_pkg::fpc_addr_t i_cmd_addr,
  input  wire fpc_pkg::fpc_data_t i_cmd_data,
  input  wire logic            i_accel,
  input  wire logic            i_ready_busy_n,
  output logic                 o_cmd_ready,
  output logic                 o_cmd_done,
  output logic                 o_bypass,
  output logic                 o_window_open,
  output logic                 o_window_late,
  output logic                 o_busy,
  output logic                 o_we_n,
  output logic                 o_ce_n,
  output logic                 o_reset_n,
  output logic                 o_accel_high,
  output logic [21:0]          o_addr,
  output logic [15:0]          o_data,
  output logic                 o_data_oe
);
  import fpc_pkg::*;
  localparam int WIN_CYC = (`FPC_T_WINDOW_NS * `FPC_CLK_MHZ) / 1000;
  localparam int RST_CYC = (`FPC_T_RESET_NS * `FPC_CLK_MHZ + 999) / 1000;
  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_WRITE  = 5'b00010,
    ST_WAIT   = 5'b00100,
    ST_BUSY   = 5'b01000,
    ST_HWRST  = 5'b10000
  } fpc_host_st_t;

  // ***************************************************
  // command word tables
  // ***************************************************
  // unlock pair, shared by every full sequence
  function automatic logic [37:0] unlock_word(input logic sel);
    unlock_word = sel ? {`FPC_UNLOCK2_ADDR, `FPC_UNLOCK2_DATA}
                      : {`FPC_UNLOCK1_ADDR, `FPC_UNLOCK1_DATA};
  endfunction : unlock_word
  // write n of a sequence for the given op
  function automatic logic [37:0] seq_word(input fpc_op_t op,
                                           input logic [2:0] n,
                                           input logic [37:0] user);
    seq_word = user;
    unique case (op)
      FPC_OP_PROGRAM:
        if (n < 3'd2) seq_word = unlock_word(n[0]);
        else if (n == 3'd2)
          seq_word = {`FPC_UNLOCK1_ADDR, `FPC_CMD_PROGRAM};
      FPC_OP_BYP_ENTER:
        if (n < 3'd2) seq_word = unlock_word(n[0]);
        else seq_word = {user[37:16], `FPC_CMD_BYPASS};
      FPC_OP_BYP_PROG:
        if (n == 3'd0) seq_word = {user[37:16], `FPC_CMD_PROGRAM};
      FPC_OP_BYP_EXIT:
        seq_word = (n == 3'd0) ? {user[37:16], `FPC_CMD_BYP_RST1}
                               : {user[37:16], `FPC_CMD_BYP_RST2};
      FPC_OP_CHIP_ERASE, FPC_OP_SECT_ERASE:
        if (n == 3'd2)
          seq_word = {`FPC_UNLOCK1_ADDR, `FPC_CMD_ERASE_SET};
        else if (n < 3'd5) seq_word = unlock_word(n[0] ^ n[1] ^ n[2]);
        else if (op == FPC_OP_CHIP_ERASE)
          seq_word = {`FPC_UNLOCK1_ADDR, `FPC_CMD_CHIP_ERASE};
        else seq_word = {user[37:16], `FPC_CMD_SECT_ERASE};
      FPC_OP_SECT_ADD:
        seq_word = {user[37:16], `FPC_CMD_SECT_ERASE};
      FPC_OP_RESET:
        seq_word = {user[37:16], `FPC_CMD_RESET};
      FPC_OP_SUSPEND:
        seq_word = {user[37:16], `FPC_CMD_SUSPEND};
      default: seq_word = user;
    endcase
  endfunction : seq_word
  function automatic logic [2:0] seq_len(input fpc_op_t op);
    unique case (op)
      FPC_OP_PROGRAM:                      seq_len = 3'd4;
      FPC_OP_BYP_ENTER:                    seq_len = 3'd3;
      FPC_OP_BYP_PROG, FPC_OP_BYP_EXIT:    seq_len = 3'd2;
      FPC_OP_CHIP_ERASE, FPC_OP_SECT_ERASE: seq_len = 3'd6;
      default:                             seq_len = 3'd1;
    endcase
  endfunction : seq_len

  // ***************************************************
  // state
  // ***************************************************
  fpc_host_st_t state_ff;
  fpc_op_t      op_ff;
  logic [2:0]   idx_ff;
  logic [37:0]  user_ff;
  logic [15:0]  win_ff;
  logic [9:0]   rst_cnt_ff;
  logic         rdy_s1_ff, rdy_s2_ff, rdy_s3_ff, rdy_ff;
  logic         acc_s1_ff, acc_s2_ff, acc_s3_ff, acc_ff;
  logic         stb_req_ff;
  logic [37:0]  stb_word;
  logic         cmd_legal;
  fpc_strobe_if sif ();

  assign stb_word = seq_word(op_ff, idx_ff, user_ff);
  assign sif.req  = stb_req_ff;
  assign sif.addr = stb_word[37:16];
  assign sif.data = stb_word[15:0];

  // in bypass only bypass ops and hardware reset are sent; busy device takes only suspend and hardware reset
  always_comb begin
    cmd_legal = 1'b1;
    if (o_bypass)
      cmd_legal = (i_cmd_op == FPC_OP_BYP_PROG) ||
                  (i_cmd_op == FPC_OP_BYP_EXIT) ||
                  (i_cmd_op == FPC_OP_HW_RESET);
    else if (i_cmd_op == FPC_OP_BYP_PROG || i_cmd_op == FPC_OP_BYP_EXIT)
      cmd_legal = 1'b0;
    if (o_busy && i_cmd_op != FPC_OP_HW_RESET &&
        i_cmd_op != FPC_OP_SUSPEND)
      cmd_legal = 1'b0;
  end

  // ready/busy and accelerate request pass three flops, then a flop loaded only when the last two agree
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      {rdy_s1_ff, rdy_s2_ff, rdy_s3_ff, rdy_ff} <= 4'hF;
      {acc_s1_ff, acc_s2_ff, acc_s3_ff, acc_ff} <= 4'h0;
    end else begin
      rdy_s1_ff <= i_ready_busy_n;
      rdy_s2_ff <= rdy_s1_ff;
      rdy_s3_ff <= rdy_s2_ff;
      if (rdy_s2_ff == rdy_s3_ff) rdy_ff <= rdy_s3_ff;
      acc_s1_ff <= i_accel;
      acc_s2_ff <= acc_s1_ff;
      acc_s3_ff <= acc_s2_ff;
      if (acc_s2_ff == acc_s3_ff) acc_ff <= acc_s3_ff;
    end
  end

  // ***************************************************
  // sequencer
  // ***************************************************
  always_ff @(posedge I_CORE_CLK) begin
    o_cmd_done <= 1'b0;
    if (I_RST) begin
      state_ff    <= ST_IDLE;
      op_ff       <= FPC_OP_RESET;
      idx_ff      <= 3'd0;
      user_ff     <= '0;
      stb_req_ff  <= 1'b0;
      o_cmd_ready <= 1'b0;
      o_busy      <= 1'b0;
      o_reset_n   <= 1'b1;
      rst_cnt_ff  <= 10'h000;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          o_cmd_ready <= 1'b1;
          if (i_cmd_valid && o_cmd_ready && cmd_legal) begin
            o_cmd_ready <= 1'b0;
            op_ff       <= i_cmd_op;
            user_ff     <= {i_cmd_addr, i_cmd_data};
            idx_ff      <= 3'd0;
            if (i_cmd_op == FPC_OP_HW_RESET) begin
              o_reset_n  <= 1'b0;
              rst_cnt_ff <= 10'(RST_CYC);
              state_ff   <= ST_HWRST;
            end else begin
              stb_req_ff <= 1'b1;
              state_ff   <= ST_WRITE;
            end
          end else if (i_cmd_valid && o_cmd_ready) begin
            o_cmd_ready <= 1'b0;
            o_cmd_done  <= 1'b1; // refused command, no bus cycle
          end
        end
        ST_WRITE: begin
          stb_req_ff <= 1'b0;
          state_ff   <= ST_WAIT;
        end
        ST_WAIT: if (sif.done) begin
          if (idx_ff + 3'd1 < seq_len(op_ff)) begin
            idx_ff     <= idx_ff + 3'd1;
            stb_req_ff <= 1'b1;
            state_ff   <= ST_WRITE;
          end else if (op_ff == FPC_OP_PROGRAM ||
                       op_ff == FPC_OP_BYP_PROG ||
                       op_ff == FPC_OP_CHIP_ERASE) begin
            o_busy   <= 1'b1;
            state_ff <= ST_BUSY;
          end else begin
            o_cmd_done <= 1'b1;
            state_ff   <= ST_IDLE;
          end
        end
        ST_BUSY: if (rdy_ff) begin // wait for device to finish
          o_busy     <= 1'b0;
          o_cmd_done <= 1'b1;
          state_ff   <= ST_IDLE;
        end
        ST_HWRST: if (rst_cnt_ff <= 10'h001) begin
          o_reset_n  <= 1'b1;
          o_busy     <= 1'b0;
          o_cmd_done <= 1'b1;
          state_ff   <= ST_IDLE;
        end else rst_cnt_ff <= rst_cnt_ff - 10'h001;
      endcase
    end
  end

  // bypass tracking: command entry or accelerate pin
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      o_bypass     <= 1'b0;
      o_accel_high <= 1'b0;
    end else begin
      o_accel_high <= acc_ff && (o_bypass || state_ff == ST_IDLE);
      if (state_ff == ST_HWRST) o_bypass <= 1'b0;
      else if (acc_ff) o_bypass <= 1'b1;
      else if (state_ff == ST_WAIT && sif.done &&
               idx_ff + 3'd1 == seq_len(op_ff)) begin
        if (op_ff == FPC_OP_BYP_ENTER) o_bypass <= 1'b1;
        else if (op_ff == FPC_OP_BYP_EXIT) o_bypass <= 1'b0;
      end
    end
  end

  // sector accumulation window, timed from final chip select rise
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      win_ff        <= 16'h0000;
      o_window_open <= 1'b0;
      o_window_late <= 1'b0;
    end else if (state_ff == ST_HWRST) begin
      win_ff        <= 16'h0000;
      o_window_open <= 1'b0;
    end else if (state_ff == ST_WAIT && sif.done &&
                 idx_ff + 3'd1 == seq_len(op_ff) &&
                 (op_ff == FPC_OP_SECT_ERASE || op_ff == FPC_OP_SECT_ADD)) begin
      win_ff        <= 16'(WIN_CYC);
      o_window_open <= 1'b1;
      o_window_late <= 1'b0;
    end else if (o_window_open && state_ff == ST_WRITE &&
                 op_ff != FPC_OP_SECT_ADD) begin
      o_window_open <= 1'b0;
    end else if (o_window_open) begin
      if (win_ff <= 16'h0001) begin
        o_window_open <= 1'b0;
        o_window_late <= 1'b1; // erase may have begun
      end else win_ff <= win_ff - 16'h0001;
    end
  end

  fpc_strobe u_strobe (
    .i_clk     (I_CORE_CLK),
    .i_rst     (I_RST),
    .bus       (sif),
    .o_we_n    (o_we_n),
    .o_ce_n    (o_ce_n),
    .o_addr    (o_addr),
    .o_data    (o_data),
    .o_data_oe (o_data_oe)
  );
endmodule : fpc_host

// [tb/fpc_host_assertions.sv]
// port-level checks for the flash command host
`timescale 1ns/10ps
module fpc_host_assertions (
  input  wire logic             I_CORE_CLK,
  input  wire logic             I_RST,
  input  wire logic             i_cmd_valid,
  input  wire fpc_pkg::fpc_op_t i_cmd_op,
  input  wire logic             o_cmd_ready,
  input  wire logic             o_cmd_done,
  input  wire logic             o_bypass,
  input  wire logic             o_busy,
  input  wire logic             o_we_n,
  input  wire logic             o_ce_n,
  input  wire logic             o_reset_n,
  input  wire logic [21:0]      o_addr,
  input  wire logic [15:0]      o_data,
  input  wire logic             o_data_oe
);
  import fpc_pkg::*;
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (I_RST);
  // write pulse and command take
  sequence we_pulse_s;
    !o_we_n [*5] ##1 o_we_n;
  endsequence
  sequence take_s;
    i_cmd_valid && o_cmd_ready;
  endsequence
  // strobe and bus relations
  we_width_a: assert property ($fell(o_we_n) |-> we_pulse_s)
    else $error("write strobe width wrong");
  we_in_ce_a: assert property (!o_we_n |-> !o_ce_n && o_data_oe)
    else $error("write strobe outside select");
  bus_stable_a: assert property (!o_we_n && $past(!o_we_n)
    |-> $stable(o_addr) && $stable(o_data)) else $error("bus moved");
  // handshake and hardware reset relations
  done_pulse_a: assert property (o_cmd_done |=> !o_cmd_done)
    else $error("done longer than one cycle");
  take_drop_a: assert property (take_s |=>
    ((!o_cmd_ready && o_cmd_done) or (!o_cmd_ready [*2])))
    else $error("ready stayed high after take");
  busy_block_a: assert property (o_busy |-> !o_cmd_ready)
    else $error("ready while busy");
  byp_refuse_a: assert property (take_s ##0 (o_bypass &&
    i_cmd_op == FPC_OP_PROGRAM) |-> ##1 (o_cmd_done && o_we_n))
    else $error("program in bypass not refused");
  reset_quiet_a: assert property (!o_reset_n |-> o_we_n && o_ce_n)
    else $error("strobe during hardware reset");
endmodule : fpc_host_assertions
bind fpc_host fpc_host_assertions u_chk (
  .I_CORE_CLK(I_CORE_CLK), .I_RST(I_RST), .i_cmd_valid(i_cmd_valid),
  .i_cmd_op(i_cmd_op), .o_cmd_ready(o_cmd_ready), .o_cmd_done(o_cmd_done),
  .o_bypass(o_bypass), .o_busy(o_busy), .o_we_n(o_we_n), .o_ce_n(o_ce_n),
  .o_reset_n(o_reset_n), .o_addr(o_addr), .o_data(o_data),
  .o_data_oe(o_data_oe)
);

// [tb/fpc_flash_model.sv]
// behavioural flash device answering the host's write cycles
`timescale 1ns/10ps
module fpc_flash_model #(
  parameter int BUSY_CYC = 40
) (
  input  wire logic        i_clk,
  input  wire logic        i_we_n,
  input  wire logic        i_reset_n,
  input  wire logic        i_accel_high,
  input  wire logic [15:0] i_data,
  output logic             o_ready_busy_n
);
  logic [2:0] step_ff = 3'h0;
  logic       byp_ff = 1'b0;
  logic       we_q_ff;
  int         busy_ff;
  logic [7:0] d;
  assign d = i_data[7:0];
  // pin low while an embedded routine runs
  assign o_ready_busy_n = (busy_ff == 0);
  // command decoder, data taken at strobe rise
  always_ff @(posedge i_clk) begin
    we_q_ff <= i_we_n;
    if (!i_reset_n) begin // abort at once
      busy_ff <= 0;
      step_ff <= 3'h0;
      byp_ff  <= 1'b0;
    end else if (busy_ff != 0) begin
      busy_ff <= busy_ff - 1; // writes ignored
    end else if (i_we_n && !we_q_ff) begin
      step_ff <= 3'h0;
      if (byp_ff || i_accel_high) begin
        case ({step_ff, d})
          {3'h0, 8'hA0}: step_ff <= 3'h1;
          {3'h0, 8'h90}: step_ff <= 3'h2;
          {3'h2, 8'h00}: byp_ff <= 1'b0;
          default: busy_ff <= (step_ff == 3'h1) ? BUSY_CYC : 0;
        endcase
      end else begin
        case ({step_ff, d})
          {3'h0, 8'hAA}: step_ff <= 3'h1;
          {3'h1, 8'h55}: step_ff <= 3'h2;
          {3'h2, 8'hA0}: step_ff <= 3'h3;
          {3'h2, 8'h20}: byp_ff <= 1'b1;
          {3'h2, 8'h80}: step_ff <= 3'h4;
          {3'h4, 8'hAA}: step_ff <= 3'h5;
          {3'h5, 8'h55}: step_ff <= 3'h6;
          default: busy_ff <= (step_ff == 3'h3 || (step_ff == 3'h6 &&
            (d == 8'h10 || d == 8'h30))) ? BUSY_CYC : 0;
        endcase
      end
    end
  end
endmodule : fpc_flash_model

// [tb/tb_top.sv]
// self-checking bench for the flash command host
`timescale 1ns/10ps
module tb_top;
  import fpc_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        valid = 1'b0;
  logic        accel = 1'b0;
  fpc_op_t     op = FPC_OP_RESET;
  fpc_addr_t   addr = '0;
  fpc_data_t   data = '0;
  logic        rdy_n, ready, done, bypass, w_open, w_late, busy;
  logic        we_n, ce_n, reset_n, acc_hi, oe;
  logic [21:0] b_addr;
  logic [15:0] b_data;
  logic [37:0] wr_q[$];
  logic [37:0] ex_q[$];
  logic        rst_seen = 1'b0;
  int          fails = 0;
  int          n_compared = 0;
  always #4 clk = ~clk;
  // record completed write cycles and reset pulses
  always @(posedge we_n) if (!rst) wr_q.push_back({b_addr, b_data});
  always @(negedge reset_n) rst_seen = 1'b1;
  fpc_host DUT (.I_CORE_CLK(clk), .I_RST(rst), .i_cmd_valid(valid),
    .i_cmd_op(op), .i_cmd_addr(addr), .i_cmd_data(data), .i_accel(accel),
    .i_ready_busy_n(rdy_n), .o_cmd_ready(ready), .o_cmd_done(done),
    .o_bypass(bypass), .o_window_open(w_open), .o_window_late(w_late),
    .o_busy(busy), .o_we_n(we_n), .o_ce_n(ce_n), .o_reset_n(reset_n),
    .o_accel_high(acc_hi), .o_addr(b_addr), .o_data(b_data),
    .o_data_oe(oe));
  fpc_flash_model u_flash (.i_clk(clk), .i_we_n(we_n), .i_reset_n(reset_n),
    .i_accel_high(acc_hi), .i_data(b_data), .o_ready_busy_n(rdy_n));
  task automatic chk(input logic [37:0] seen, input logic [37:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic ex(input fpc_addr_t a, input fpc_data_t d);
    ex_q.push_back({a, d});
  endtask : ex
  task automatic unl();
    ex(22'h000555, 16'h00AA);
    ex(22'h0002AA, 16'h0055);
  endtask : unl
  // compare recorded writes with the expected list
  task automatic cmp_wr();
    chk(38'(wr_q.size()), 38'(ex_q.size()));
    while (wr_q.size() > 0 && ex_q.size() > 0) begin
      chk(wr_q.pop_front(), ex_q.pop_front());
    end
    wr_q.delete();
    ex_q.delete();
  endtask : cmp_wr
  // offer one command, wait for its completion
  task automatic issue(input fpc_op_t o, input fpc_addr_t a,
                       input fpc_data_t d);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 9000) begin
      @(posedge clk);
      #1;
      n++;
    end
    valid = 1'b1;
    op = o;
    addr = a;
    data = d;
    @(posedge clk);
    #1;
    valid = 1'b0;
    while (done !== 1'b1 && n < 18000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 18000) fails++;
  endtask : issue
  task automatic t_program();
    unl();
    ex(22'h000555, 16'h00A0);
    ex(22'h012345, 16'h5A3C);
    issue(FPC_OP_PROGRAM, 22'h012345, 16'h5A3C);
    cmp_wr();
    $display("program test done");
  endtask : t_program
  task automatic t_bypass();
    issue(FPC_OP_BYP_PROG, 22'h000100, 16'h1111);
    cmp_wr();
    unl();
    ex(22'h100555, 16'h0020);
    issue(FPC_OP_BYP_ENTER, 22'h100555, 16'h0000);
    chk(38'(bypass), 38'h1);
    ex(22'h100010, 16'h00A0);
    ex(22'h100010, 16'hC3C3);
    issue(FPC_OP_BYP_PROG, 22'h100010, 16'hC3C3);
    ex(22'h100012, 16'h00A0);
    ex(22'h100012, 16'h0000);
    issue(FPC_OP_BYP_PROG, 22'h100012, 16'h0000);
    issue(FPC_OP_PROGRAM, 22'h000200, 16'h1234);
    cmp_wr();
    ex(22'h100000, 16'h0090);
    ex(22'h100000, 16'h0000);
    issue(FPC_OP_BYP_EXIT, 22'h100000, 16'h0000);
    cmp_wr();
    chk(38'(bypass), 38'h0);
    unl();
    ex(22'h100555, 16'h0020);
    issue(FPC_OP_BYP_ENTER, 22'h100555, 16'h0000);
    issue(FPC_OP_HW_RESET, 22'h000000, 16'h0000);
    cmp_wr();
    chk(38'(rst_seen), 38'h1);
    chk(38'(bypass), 38'h0);
    $display("bypass test done");
  endtask : t_bypass
  // accelerate request forces bypass; two-cycle program while held
  task automatic t_accel();
    accel = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    chk(38'(bypass), 38'h1);
    chk(38'(acc_hi), 38'h1);
    ex(22'h100020, 16'h00A0);
    ex(22'h100020, 16'h0F0F);
    issue(FPC_OP_BYP_PROG, 22'h100020, 16'h0F0F);
    cmp_wr();
    accel = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    chk(38'(acc_hi), 38'h0);
    ex(22'h100000, 16'h0090);
    ex(22'h100000, 16'h0000);
    issue(FPC_OP_BYP_EXIT, 22'h100000, 16'h0000);
    cmp_wr();
    chk(38'(bypass), 38'h0);
    $display("accelerate test done");
  endtask : t_accel
  // full six-write sector erase ending with the window open
  task automatic sect(input fpc_addr_t a);
    unl();
    ex(22'h000555, 16'h0080);
    unl();
    ex(a, 16'h0030);
    issue(FPC_OP_SECT_ERASE, a, 16'h0000);
    cmp_wr();
    chk(38'(w_open), 38'h1);
  endtask : sect
  task automatic t_erase();
    unl();
    ex(22'h000555, 16'h0080);
    unl();
    ex(22'h000555, 16'h0010);
    issue(FPC_OP_CHIP_ERASE, 22'h000000, 16'h0000);
    cmp_wr();
    sect(22'h040000);
    ex(22'h050000, 16'h0030);
    issue(FPC_OP_SECT_ADD, 22'h050000, 16'h0000);
    cmp_wr();
    ex(22'h000000, 16'h00F0);
    issue(FPC_OP_RESET, 22'h000000, 16'h0000);
    cmp_wr();
    chk(38'(w_open), 38'h0);
    sect(22'h060000);
    ex(22'h060000, 16'h00B0);
    issue(FPC_OP_SUSPEND, 22'h060000, 16'h0000);
    cmp_wr();
    chk(38'(w_open), 38'h0);
    sect(22'h070000);
    repeat (6300) @(posedge clk);
    chk(38'(w_late), 38'h1);
    $display("erase test done");
  endtask : t_erase
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    t_program();
    t_bypass();
    t_accel();
    t_erase();
    test_done();
  end
  // watchdog
  initial begin
    #200000;
    fails++;
    test_done();
  end
endmodule : tb_top
